/* File: core/aux_timer_params.svh */
// constants of the auxiliary timer pair control block
`ifndef AUX_TIMER_PARAMS_SVH
`define AUX_TIMER_PARAMS_SVH

// =====================================================================
// register byte addresses
`define AUX_A_CTRL_ADDR 16'hFF40
`define AUX_B_CTRL_ADDR 16'hFF44
`define CORE_CTRL_ADDR 16'hFF48
`define CORE_COUNT_ADDR 16'hFF4C
`define AUX_A_COUNT_ADDR 16'hFF50
`define AUX_B_COUNT_ADDR 16'hFF54

// =====================================================================
// reset values and write masks
`define CTRL_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define AUX_WRITE_MASK 16'hB3FF
`define CORE_WRITE_MASK 16'h0FFF

// =====================================================================
// field positions
`define EDGE_FLAG_BIT 12
`define DIR_CHANGE_FLAG_BIT 13

// =====================================================================
// prescaler: base divisor exponent (divide by 8, by 4 with the fast bit) and counter width
`define PRESCALE_BASE_EXP 4'h3
`define PRESCALE_WIDTH 10

`endif

/* File: core/aux_timer_pkg.sv */
// types shared by the auxiliary timer pair control block
`include "aux_timer_params.svh"
package aux_timer_pkg;

	// operating mode, codes in declaration order 000..111
	typedef enum logic [2:0] {
		MODE_TIMER, MODE_COUNTER, MODE_GATED_LOW, MODE_GATED_HIGH,
		MODE_RELOAD, MODE_CAPTURE, MODE_INCR_ROT, MODE_INCR_EDGE
	} mode_type;

	// auxiliary timer control word
	typedef struct packed {
		logic aux_irq_enable;
		logic aux_rotation_dir;
		logic aux_dir_change_flag;
		logic aux_edge_flag;
		logic [1:0] reserved;
		logic aux_remote_run_select;
		logic aux_ext_direction_enable;
		logic aux_direction_bit;
		logic aux_run_bit;
		mode_type aux_mode_field;
		logic [2:0] aux_input_select;
	} aux_ctrl_type;

	// core timer control word
	typedef struct packed {
		logic [3:0] unused;
		logic block_fast_prescale;
		logic core_toggle_latch;
		logic output_enable;
		logic ext_direction_enable;
		logic direction_bit;
		logic run_bit;
		mode_type mode;
		logic [2:0] core_input_select;
	} core_ctrl_type;

	// edges of one signal
	typedef struct packed {
		logic rise;
		logic fall;
	} edge_type;

	// prescaler tick: low exponent bits of the free counter all ones
	function automatic logic prescale_hit(input logic [9:0] cnt,
		input logic [2:0] code, input logic fast);
		logic [3:0] exp_bits;
		logic [9:0] mask;
		exp_bits = `PRESCALE_BASE_EXP + {1'b0, code} - {3'h0, fast};
		mask = ~(10'h3FF << exp_bits);
		return (cnt & mask) == mask;
	endfunction

endpackage

/* File: core/pin_sync.sv */
// three-stage synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// pins and filtered levels
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// shift chain; the first stage feeds only the second
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit follows only when the last two stages agree
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			level_o <= '0;
		else
			for (int i = 0; i < WIDTH; i++)
				if (stage2[i] == stage3[i])
					level_o[i] <= stage3[i];
	end
endmodule
`default_nettype wire

/* File: core/aux_timer_unit.sv */
// one auxiliary 16-bit timer: mode decode, run, direction and count
`include "aux_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module aux_timer_unit (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// control from the register file
	input wire aux_timer_pkg::aux_ctrl_type ctrl_i,
	input wire logic core_run_i,
	input wire logic fast_i,
	input wire logic [9:0] presc_i,
	// count sources
	input wire aux_timer_pkg::edge_type latch_edge_i,
	input wire logic gate_i,
	input wire logic dir_pin_i,
	// results
	output logic [15:0] count_o,
	output logic dir_o,
	output logic step_o,
	output logic dir_change_o
);
	logic running;
	logic next_dir;
	logic tick;
	logic latch_step;

	// run source: own bit or the core run bit
	assign running = ctrl_i.aux_remote_run_select ? core_run_i
		: ctrl_i.aux_run_bit;
	// direction: pin when enabled, else software bit
	assign next_dir = ctrl_i.aux_ext_direction_enable ? dir_pin_i
		: ctrl_i.aux_direction_bit;
	assign tick = aux_timer_pkg::prescale_hit(presc_i,
		ctrl_i.aux_input_select, fast_i);
	// toggle latch edge selection; x00 and 001..011 count nothing
	always_comb
	begin
		unique case (ctrl_i.aux_input_select)
			3'h5: latch_step = latch_edge_i.rise;
			3'h6: latch_step = latch_edge_i.fall;
			3'h7: latch_step = latch_edge_i.rise | latch_edge_i.fall;
			default: latch_step = 1'b0;
		endcase
	end

	// mode decode; reload and capture modes never count
	always_comb
	begin
		unique case (ctrl_i.aux_mode_field)
			aux_timer_pkg::MODE_TIMER: step_o = running & tick;
			aux_timer_pkg::MODE_GATED_LOW: step_o = running & tick & ~gate_i;
			aux_timer_pkg::MODE_GATED_HIGH: step_o = running & tick & gate_i;
			aux_timer_pkg::MODE_COUNTER,
			aux_timer_pkg::MODE_INCR_ROT,
			aux_timer_pkg::MODE_INCR_EDGE: step_o = running & latch_step;
			aux_timer_pkg::MODE_RELOAD,
			aux_timer_pkg::MODE_CAPTURE: step_o = 1'b0;
		endcase
	end

	assign dir_change_o = next_dir != dir_o;

	// current direction
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dir_o <= 1'b0;
		else
			dir_o <= next_dir;
	end

	// counter
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_o <= `COUNT_RESET;
		else if (step_o)
			count_o <= dir_o ? count_o - 16'h0001 : count_o + 16'h0001;
	end
endmodule
`default_nettype wire

/* File: core/aux_timer_pair_control.sv */
// two auxiliary timers with core timer, toggle latch and APB registers
//
// Added by the designer: the APB interface to the registers.
`include "aux_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module aux_timer_pair_control (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// external pins
	input wire logic core_count_pin_i,
	input wire logic core_direction_pin_i,
	input wire logic [1:0] aux_count_pin_i,
	input wire logic [1:0] aux_direction_pin_i,
	// outputs
	output logic core_toggle_latch_o,
	output logic [1:0] aux_irq_o
);

	// =================================================================
	// declarations
	aux_timer_pkg::core_ctrl_type core_ctrl;
	aux_timer_pkg::aux_ctrl_type aux_ctrl [2];
	logic [15:0] core_count;
	logic [9:0] presc;
	logic [5:0] pin_level;
	logic [5:0] pin_prev;
	logic core_cnt_rise;
	logic core_cnt_fall;
	logic core_dir_any;
	logic core_dir;
	logic core_tick;
	logic core_pin_step;
	logic core_incr_step;
	logic core_step;
	logic core_wrap;
	logic latch_prev;
	aux_timer_pkg::edge_type latch_edge;
	logic [15:0] aux_count [2];
	logic [1:0] aux_dir;
	logic [1:0] aux_step;
	logic [1:0] aux_dir_change;
	logic bus_write;
	logic bus_setup;
	logic addr_hit;
	logic [15:0] read_word;
	logic [15:0] wdata;
	logic access;
	logic core_ctrl_sel;
	logic [1:0] aux_ctrl_sel;

	// every register is 16 bits wide; the upper bus half is dropped
	assign wdata = pwdata_i[15:0];

	// =================================================================
	// pin synchronisation and edge detection
	// filtered level bits:
	// 0 core count pin, also the core gate
	// 1 core direction pin
	// 3:2 gates of timer a and timer b
	// 5:4 direction pins of timer a and timer b
	// pins are asynchronous, so nothing reads them before the filter
	pin_sync #(
		.WIDTH(6)
	) pins (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.pin_i({aux_direction_pin_i, aux_count_pin_i,
			core_direction_pin_i, core_count_pin_i}),
		.level_o(pin_level)
	);

	// previous filtered samples for edge comparison
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pin_prev <= 6'h00;
		else
			pin_prev <= pin_level;
	end

	assign core_cnt_rise = pin_level[0] & ~pin_prev[0];
	assign core_cnt_fall = ~pin_level[0] & pin_prev[0];
	assign core_dir_any = pin_level[1] ^ pin_prev[1];

	// =================================================================
	// shared prescaler
	// free-running divider; every divisor is a power of two
	// one counter serves all timers, so equal codes tick together
	// the ticks of a code are evenly spaced whatever its phase
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc <= 10'h000;
		else
			presc <= presc + 10'h001;
	end

	assign core_tick = aux_timer_pkg::prescale_hit(presc,
		core_ctrl.core_input_select,
		core_ctrl.block_fast_prescale);

	// =================================================================
	// core timer
	assign core_dir = core_ctrl.ext_direction_enable ? pin_level[1]
		: core_ctrl.direction_bit;

	// counter mode edge selection
	always_comb
	begin
		unique case (core_ctrl.core_input_select)
			3'h1: core_pin_step = core_cnt_rise;
			3'h2: core_pin_step = core_cnt_fall;
			3'h3: core_pin_step = core_cnt_rise | core_cnt_fall;
			default: core_pin_step = 1'b0;
		endcase
	end

	// incremental mode edge selection
	always_comb
	begin
		unique case (core_ctrl.core_input_select)
			3'h1: core_incr_step = core_cnt_rise | core_cnt_fall;
			3'h2: core_incr_step = core_dir_any;
			3'h3: core_incr_step = core_cnt_rise | core_cnt_fall
				| core_dir_any;
			default: core_incr_step = 1'b0;
		endcase
	end

	// core mode decode; codes 100 and 101 are not used by the core
	always_comb
	begin
		unique case (core_ctrl.mode)
			aux_timer_pkg::MODE_TIMER: core_step = core_tick;
			aux_timer_pkg::MODE_COUNTER: core_step = core_pin_step;
			aux_timer_pkg::MODE_GATED_LOW:
				core_step = core_tick & ~pin_level[0];
			aux_timer_pkg::MODE_GATED_HIGH:
				core_step = core_tick & pin_level[0];
			aux_timer_pkg::MODE_INCR_ROT,
			aux_timer_pkg::MODE_INCR_EDGE: core_step = core_incr_step;
			aux_timer_pkg::MODE_RELOAD,
			aux_timer_pkg::MODE_CAPTURE: core_step = 1'b0;
		endcase
		core_step = core_step & core_ctrl.run_bit;
	end

	// over- or underflow on the step that wraps the counter
	assign core_wrap = core_step & (core_dir ? core_count == 16'h0000
		: core_count == 16'hFFFF);

	// core counter
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			core_count <= `COUNT_RESET;
		else if (core_step)
			core_count <= core_dir ? core_count - 16'h0001
				: core_count + 16'h0001;
	end

	// core control; a software write to the latch wins over a wrap
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			core_ctrl <= aux_timer_pkg::core_ctrl_type'(`CTRL_RESET);
		else if (core_ctrl_sel)
			core_ctrl <= aux_timer_pkg::core_ctrl_type'(
				wdata & `CORE_WRITE_MASK);
		else if (core_wrap)
			core_ctrl.core_toggle_latch <= ~core_ctrl.core_toggle_latch;
	end

	assign core_toggle_latch_o = core_ctrl.core_toggle_latch;

	// latch edges seen by the auxiliary timers
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			latch_prev <= 1'b0;
		else
			latch_prev <= core_ctrl.core_toggle_latch;
	end

	assign latch_edge.rise = core_ctrl.core_toggle_latch & ~latch_prev;
	assign latch_edge.fall = ~core_ctrl.core_toggle_latch & latch_prev;

	// =================================================================
	// auxiliary timers
	for (genvar u = 0; u < 2; u++)
	begin : aux
		aux_timer_unit unit (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.ctrl_i(aux_ctrl[u]),
			.core_run_i(core_ctrl.run_bit),
			.fast_i(core_ctrl.block_fast_prescale),
			.presc_i(presc),
			.latch_edge_i(latch_edge),
			.gate_i(pin_level[2 + u]),
			.dir_pin_i(pin_level[4 + u]),
			.count_o(aux_count[u]),
			.dir_o(aux_dir[u]),
			.step_o(aux_step[u]),
			.dir_change_o(aux_dir_change[u])
		);
	end

	// auxiliary control words; hardware set wins over a software clear
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aux_ctrl[0] <= aux_timer_pkg::aux_ctrl_type'(`CTRL_RESET);
			aux_ctrl[1] <= aux_timer_pkg::aux_ctrl_type'(`CTRL_RESET);
		end
		else
			for (int u = 0; u < 2; u++)
			begin
				// software fields; reserved and read-only bits masked off
				if (aux_ctrl_sel[u])
					aux_ctrl[u] <= aux_timer_pkg::aux_ctrl_type'(
						wdata & `AUX_WRITE_MASK);
				// a count edge in the write cycle keeps the flag set
				if (aux_step[u])
					aux_ctrl[u].aux_edge_flag <= 1'b1;
				else if (aux_ctrl_sel[u])
					aux_ctrl[u].aux_edge_flag <= wdata[`EDGE_FLAG_BIT];
				// a direction change in the write cycle wins likewise
				if (aux_dir_change[u])
					aux_ctrl[u].aux_dir_change_flag <= 1'b1;
				else if (aux_ctrl_sel[u])
					aux_ctrl[u].aux_dir_change_flag
						<= wdata[`DIR_CHANGE_FLAG_BIT];
				// status bit mirrors the registered direction
				aux_ctrl[u].aux_rotation_dir <= aux_dir[u];
			end
	end

	// interrupt requests gated by the enable bit
	always_comb
	begin
		for (int u = 0; u < 2; u++)
			aux_irq_o[u] = aux_ctrl[u].aux_irq_enable
				& (aux_ctrl[u].aux_edge_flag
				| aux_ctrl[u].aux_dir_change_flag);
	end

	// =================================================================
	// APB slave
	// no wait states: every access cycle is also the completing one
	assign access = psel_i & penable_i;
	assign bus_setup = psel_i & ~penable_i;
	assign bus_write = access & pwrite_i & addr_hit;
	assign pready_o = 1'b1;
	// an unmapped address is answered with an error, never a hang
	assign pslverr_o = access & ~addr_hit;

	// =================================================================
	// write decode
	// one select per writable control word; count words ignore writes
	assign core_ctrl_sel = bus_write & (paddr_i == `CORE_CTRL_ADDR);
	assign aux_ctrl_sel[0] = bus_write & (paddr_i == `AUX_A_CTRL_ADDR);
	assign aux_ctrl_sel[1] = bus_write & (paddr_i == `AUX_B_CTRL_ADDR);

	// read multiplexer and address decode
	always_comb
	begin
		addr_hit = 1'b1;
		unique case (paddr_i)
			`AUX_A_CTRL_ADDR: read_word = aux_ctrl[0];
			`AUX_B_CTRL_ADDR: read_word = aux_ctrl[1];
			`CORE_CTRL_ADDR: read_word = core_ctrl;
			`CORE_COUNT_ADDR: read_word = core_count;
			`AUX_A_COUNT_ADDR: read_word = aux_count[0];
			`AUX_B_COUNT_ADDR: read_word = aux_count[1];
			default:
			begin
				read_word = 16'h0000;
				addr_hit = 1'b0;
			end
		endcase
	end

	// read data captured in the setup cycle, upper half zero
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prdata_o <= 32'h00000000;
		else if (bus_setup && !pwrite_i)
			prdata_o <= {16'h0000, read_word};
	end
endmodule
`default_nettype wire

/* File: tb/aux_timer_asserts.sv */
// concurrent checks on the pins of the timer pair control block
`timescale 1ns/1ps
`default_nettype none
module aux_timer_asserts (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// outputs
	input wire logic core_toggle_latch_o,
	input wire logic [1:0] aux_irq_o
);
	// ======
	// helper state
	logic acc;
	logic actl;
	logic map;
	logic [1:0] irq_en;
	assign acc = psel_i & penable_i;
	assign actl = paddr_i[15:3] == 13'h1FE8 && paddr_i[1:0] == 2'h0;
	assign map = paddr_i inside {16'hFF40, 16'hFF44, 16'hFF48, 16'hFF4C,
		16'hFF50, 16'hFF54};

	// interrupt enables as last written by software
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_en <= 2'h0;
		else if (acc && pwrite_i && actl)
			irq_en[paddr_i[2]] <= pwdata_i[15];
	end

	// ======
	// properties
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence rd_ctl;
		acc && !pwrite_i && actl;
	endsequence
	sequence wr_core;
		acc && pwrite_i && paddr_i == 16'hFF48;
	endsequence

	ready_always_a: assert property (pready_o)
		else $error("pready low");
	err_mapped_a: assert property (acc |-> pslverr_o == !map)
		else $error("slave error wrong");
	err_idle_a: assert property (!acc |-> !pslverr_o)
		else $error("slave error outside access");
	rsvd_zero_a: assert property (rd_ctl |-> prdata_o[11:10] == 2'h0)
		else $error("reserved bits not zero");
	upper_zero_a: assert property (acc && !pwrite_i |-> prdata_o[31:16] == 16'h0)
		else $error("upper read half not zero");
	unmapped_data_a: assert property (acc && !pwrite_i && !map |-> prdata_o == 0)
		else $error("unmapped read not zero");
	irq_mask_lo_a: assert property (!irq_en[0] |-> !aux_irq_o[0])
		else $error("timer a irq while disabled");
	irq_mask_hi_a: assert property (!irq_en[1] |-> !aux_irq_o[1])
		else $error("timer b irq while disabled");
	latch_write_a: assert property (wr_core |=>
		core_toggle_latch_o == $past(pwdata_i[10]))
		else $error("toggle latch not written");
endmodule

bind aux_timer_pair_control aux_timer_asserts u_chk (.mclk_i, .rst_n_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
	.pready_o, .pslverr_o, .core_toggle_latch_o, .aux_irq_o);
`default_nettype wire

/* File: tb/pin_encoder.sv */
// far-side pin model: each new level stands at least three cycles
`timescale 1ns/1ps
`default_nettype none
module pin_encoder (
	// clock
	input wire logic mclk_i,
	// wanted levels: core count, core dir, aux gates, aux dirs
	input wire logic [5:0] want_i,
	// pins
	output logic [5:0] pin_o
);
	logic [1:0] hold;
	initial pin_o = 6'h00;
	initial hold = 2'h0;

	// follow the wanted levels after the last change has stood
	always @(posedge mclk_i)
	begin
		if (hold != 2'h0)
			hold <= hold - 2'h1;
		else if (want_i != pin_o)
		begin
			pin_o <= want_i;
			hold <= 2'h2;
		end
	end
endmodule
`default_nettype wire

/* File: tb/aux_timer_pair_control_tb_top.sv */
// self-checking bench for the auxiliary timer pair control block
`timescale 1ns/1ps
`default_nettype none
module aux_timer_pair_control_tb_top;
	logic mclk_i;
	logic rst_n_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [15:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic core_toggle_latch_o;
	logic [1:0] aux_irq_o;
	logic [5:0] want;
	logic [5:0] pin;
	logic [15:0] q;
	logic [15:0] w;
	logic [1:0] dir;
	logic pd;
	int failures;
	int compares;
	int cycles;
	int seed;
	int i;

	// ======
	// design and pin model
	aux_timer_pair_control u_dut (.mclk_i, .rst_n_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.core_count_pin_i(pin[0]), .core_direction_pin_i(pin[1]),
		.aux_count_pin_i(pin[3:2]), .aux_direction_pin_i(pin[5:4]),
		.core_toggle_latch_o, .aux_irq_o);
	pin_encoder u_pins (.mclk_i, .want_i(want), .pin_o(pin));

	// clock and cycle ceiling
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			stop_test();
		end
	end

	// ======
	// tasks
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one bus transfer, read data left in q
	task automatic bus(input logic wr_en, input logic [15:0] a,
		input logic [15:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr_en;
		paddr_i <= a;
		pwdata_i <= {16'h0000, d};
		@(posedge mclk_i);
		penable_i <= 1'b1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1)
			@(posedge mclk_i);
		q = prdata_o[15:0];
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask

	// expected control word after a write with counting off
	function automatic logic [15:0] ctl_exp(input logic [15:0] v,
		input logic p);
		return (v & 16'hB3FF) | {1'b0, v[7], v[7] != p, 13'h0};
	endfunction

	// program, apply latch edges, a pin pulse or a wait, compare counts
	task automatic run_case(input logic [15:0] ca, input logic [15:0] cc,
		input logic [15:0] d, input int gap);
		logic [15:0] c0;
		logic [15:0] ra;
		logic dn;
		ra = (gap < 0) ? 16'hFF4C : 16'hFF50;
		dn = ca[8] ? 1'b0 : ca[7];
		wr(16'hFF40, ca);
		wr(16'hFF48, cc);
		bus(1'b0, ra, 16'h0);
		c0 = q;
		if (gap > 0)
			repeat (gap) @(posedge mclk_i);
		else if (gap < 0)
		begin
			want[0] <= 1'b1;
			repeat (10) @(posedge mclk_i);
			want[0] <= 1'b0;
			repeat (10) @(posedge mclk_i);
		end
		else
		begin
			wr(16'hFF48, cc | 16'h0400);
			repeat (8) @(posedge mclk_i);
			wr(16'hFF48, cc);
			repeat (8) @(posedge mclk_i);
		end
		bus(1'b0, ra, 16'h0);
		check(q - c0, d);
		if (gap == 0)
		begin
			bus(1'b0, 16'hFF40, 16'h0);
			check(q, ca | {1'b0, dn, dn != pd, d != 16'h0, 12'h0});
		end
		pd = dn;
	endtask

	// ======
	// main sequence
	initial
	begin
		mclk_i = 1'b0;
		rst_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 16'h0000;
		pwdata_i = 32'h00000000;
		want = 6'h00;
		failures = 0;
		compares = 0;
		cycles = 0;
		seed = 63;
		dir = 2'h0;
		pd = 1'b0;
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		// reset values, unmapped word, read-only count
		for (i = 0; i < 7; i++)
		begin
			bus(1'b0, 16'hFF40 + 16'(4 * i), 16'h0);
			check(q, 16'h0000);
		end
		wr(16'hFF54, 16'h1234);
		bus(1'b0, 16'hFF54, 16'h0);
		check(q, 16'h0000);
		// random control words on both timers, run bits cleared
		for (i = 0; i < 8; i++)
		begin
			w = 16'($random(seed)) & 16'hFCBF;
			wr(16'hFF40 + {13'h0, i[0], 2'h0}, w);
			repeat (4) @(posedge mclk_i);
			check({15'h0, aux_irq_o[i[0]]}, {15'h0, w[15] & (w[12] |
				w[13] | (w[7] != dir[i[0]]))});
			bus(1'b0, 16'hFF40 + {13'h0, i[0], 2'h0}, 16'h0);
			check(q, ctl_exp(w, dir[i[0]]));
			dir[i[0]] = w[7];
		end
		wr(16'hFF40, 16'h0000);
		// toggle latch edges into timer a
		run_case(16'h004D, 16'h0000, 16'h0001, 0);
		run_case(16'h004E, 16'h0000, 16'h0001, 0);
		run_case(16'h004F, 16'h0000, 16'h0002, 0);
		run_case(16'h004C, 16'h0000, 16'h0000, 0);
		run_case(16'h0075, 16'h0000, 16'h0001, 0);
		run_case(16'h0077, 16'h0000, 16'h0002, 0);
		run_case(16'h0070, 16'h0000, 16'h0000, 0);
		run_case(16'h020F, 16'h0040, 16'h0002, 0);
		run_case(16'h00CF, 16'h0000, 16'hFFFE, 0);
		run_case(16'h01CF, 16'h0000, 16'h0002, 0);
		// prescaled timer modes over 160 cycles
		run_case(16'h0040, 16'h0800, 16'h0028, 157);
		run_case(16'h0040, 16'h0000, 16'h0014, 157);
		run_case(16'h0041, 16'h0000, 16'h000A, 157);
		run_case(16'h0000, 16'h0000, 16'h0000, 157);
		run_case(16'h0058, 16'h0000, 16'h0000, 157);
		run_case(16'h0050, 16'h0000, 16'h0014, 157);
		run_case(16'h0060, 16'h0000, 16'h0000, 157);
		// core count pin pulses
		run_case(16'h0000, 16'h0049, 16'h0001, -1);
		run_case(16'h0000, 16'h004A, 16'h0001, -1);
		run_case(16'h0000, 16'h004B, 16'h0002, -1);
		run_case(16'h0000, 16'h0048, 16'h0000, -1);
		run_case(16'h0000, 16'h004C, 16'h0000, -1);
		run_case(16'h0000, 16'h0071, 16'h0002, -1);
		run_case(16'h0000, 16'h0072, 16'h0000, -1);
		run_case(16'h0000, 16'h0073, 16'h0002, -1);
		// direction taken from the aux direction pin
		want[4] <= 1'b1;
		repeat (8) @(posedge mclk_i);
		wr(16'hFF40, 16'h0100);
		repeat (8) @(posedge mclk_i);
		bus(1'b0, 16'hFF40, 16'h0);
		check(q, 16'h6100);
		stop_test();
	end
endmodule
`default_nettype wire
